// ### src/flash_host_regs.vh
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH

// register word offsets (byte addresses)
`define REG_CTRL         8'h00
`define REG_ADDR         8'h04
`define REG_WDATA        8'h08
`define REG_STATUS       8'h0C
`define REG_RDATA        8'h10
`define REG_PROT         8'h14
`define REG_SECT         8'h18

// control word fields
`define CTRL_OP          3:0
`define CTRL_AUTO_RST    4
`define CTRL_HV_RST      5
`define CTRL_SEL         7:6

// status word fields
`define STAT_BUSY        0
`define STAT_DONE        1
`define STAT_REFUSED     2
`define STAT_LOCKOUT     3
`define STAT_ID_MODE     4
`define STAT_TIMEOUT     5
`define STAT_HV_RST      6

// operation codes
`define OP_READ          4'h0
`define OP_WRITE         4'h1
`define OP_RESET         4'h2
`define OP_ASEL          4'h3
`define OP_PROG          4'h4
`define OP_HVID          4'h5

// identification selections on address lines one and zero
`define HVSEL_MANUF      2'h0
`define HVSEL_DEVICE     2'h1
`define HVSEL_PROT       2'h2

// command cycle addresses and data (word mode)
`define UNLOCK1_ADDR     12'h555
`define UNLOCK2_ADDR     12'h2AA
`define UNLOCK1_DATA     16'h00AA
`define UNLOCK2_DATA     16'h0055
`define CMD_ASEL         16'h0090
`define CMD_PROG         16'h00A0
`define CMD_RESET        16'h00F0

`define TIMEOUT_FLAG_POS 5
`define NUM_SECTORS      5'h16

// reset values
`define RST_ADDR         19'h00000
`define RST_WDATA        16'h0000
`define RST_SECT         5'h00
`define RST_PROT         22'h000000

// timing
`define CLK_PERIOD_NS    8
`define T_GLITCH_NS      5
`define T_WP_NS          35
`define T_ACC_NS         70
`define SYNC_CYCLES      2
`define GLITCH_CYCLES    ((`T_GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WP_CYCLES        ((`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACC_CYCLES       ((`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### src/flash_bus_cycle.v
`timescale 1ns/1ps
`include "flash_host_regs.vh"
module flash_bus_cycle (
   input  wire        aclk,         // system clock
   input  wire        aresetn,      // synchronous reset, active low
   input  wire        start,        // one-cycle request for a bus cycle
   input  wire        is_write,     // 1 write cycle, 0 read cycle
   input  wire        hv,           // drive high voltage on identification line
   input  wire [18:0] addr,         // cycle address
   input  wire [15:0] wdata,        // write data
   output reg         done,         // one-cycle completion pulse
   output reg  [15:0] rdata,        // data captured by a read
   output reg  [18:0] fl_addr,      // flash address lines
   output reg  [15:0] fl_dq_o,      // flash data out
   output reg         fl_dq_oe,     // flash data enable
   input  wire [15:0] fl_dq_i,      // flash data in
   output reg         fl_ce_n,      // chip select, active low
   output reg         fl_oe_n,      // output enable, active low
   output reg         fl_we_n,      // write strobe, active low
   output reg         fl_hv_id_en   // high voltage on identification line
);
   localparam B_IDLE   = 4'b0001;
   localparam B_SETUP  = 4'b0010;
   localparam B_STROBE = 4'b0100;
   localparam B_HOLD   = 4'b1000;
   // strobe is several cycles, far above the glitch limit
   localparam integer WP_N = `WP_CYCLES;
   localparam integer RD_N = `ACC_CYCLES + `SYNC_CYCLES;
   localparam [3:0]   WP_C = WP_N[3:0];
   localparam [3:0]   RD_C = RD_N[3:0];

   reg [3:0]  state;
   reg [3:0]  cnt;
   reg        wr_q;
   reg [15:0] dq_s1;
   reg [15:0] dq_s2;

   // pin data passes two flops before use
   always @(posedge aclk) begin
      if (!aresetn) begin
         dq_s1 <= 16'h0000;
         dq_s2 <= 16'h0000;
      end else begin
         dq_s1 <= fl_dq_i;
         dq_s2 <= dq_s1;
      end
   end

   // one bus cycle: address setup, strobe, release with data hold
   always @(posedge aclk) begin
      if (!aresetn) begin
         state       <= B_IDLE;
         cnt         <= 4'h0;
         wr_q        <= 1'b0;
         done        <= 1'b0;
         rdata       <= 16'h0000;
         fl_addr     <= `RST_ADDR;
         fl_dq_o     <= 16'h0000;
         fl_dq_oe    <= 1'b0;
         fl_ce_n     <= 1'b1;
         fl_oe_n     <= 1'b1;
         fl_we_n     <= 1'b1;
         fl_hv_id_en <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            B_IDLE: begin
               if (start) begin
                  fl_addr     <= addr;
                  fl_dq_o     <= wdata;
                  fl_dq_oe    <= is_write;
                  fl_hv_id_en <= hv & ~is_write;
                  wr_q        <= is_write;
                  state       <= B_SETUP;
               end
            end
            B_SETUP: begin
               // both strobes fall on one edge so address is stable at the later fall
               fl_ce_n <= 1'b0;
               if (wr_q) begin
                  fl_we_n <= 1'b0;
               end else begin
                  fl_oe_n <= 1'b0;
               end
               cnt   <= 4'h1;
               state <= B_STROBE;
            end
            B_STROBE: begin
               if (cnt == (wr_q ? WP_C : RD_C)) begin
                  fl_ce_n <= 1'b1;
                  fl_we_n <= 1'b1;
                  fl_oe_n <= 1'b1;
                  if (!wr_q) begin
                     rdata <= dq_s2;
                  end
                  state <= B_HOLD;
               end else begin
                  cnt <= cnt + 4'h1;
               end
            end
            B_HOLD: begin
               // data held one cycle past the rising strobe
               fl_dq_oe    <= 1'b0;
               fl_hv_id_en <= 1'b0;
               done        <= 1'b1;
               state       <= B_IDLE;
            end
            default: state <= B_IDLE;
         endcase
      end
   end
endmodule // flash_bus_cycle

// ### src/flash_id_host.v
// Overview of operation
// - high-voltage id read: select, output enable low
// - id pattern on lines six, one, zero
// - protect verify: sector bits, one high, zero low
// - protect all sectors before unprotecting
// - host holds strobes non-writing when idle
// - host resets after timeout if auto reset is set; identification mode stays until a reset op
// - command identification: codes at offsets
`timescale 1ns/1ps
`include "flash_host_regs.vh"
module flash_id_host (
   input  wire        aclk,                           // system clock, 125 MHz
   input  wire        aresetn,                        // synchronous reset, active low
   input  wire [7:0]  s_axi_awaddr,                   // write address
   input  wire        s_axi_awvalid,                  // write address valid
   output wire        s_axi_awready,                  // write address ready
   input  wire [31:0] s_axi_wdata,                    // write data
   input  wire [3:0]  s_axi_wstrb,                    // write byte lanes
   input  wire        s_axi_wvalid,                   // write data valid
   output wire        s_axi_wready,                   // write data ready
   output reg  [1:0]  s_axi_bresp,                    // write response
   output reg         s_axi_bvalid,                   // write response valid
   input  wire        s_axi_bready,                   // write response ready
   input  wire [7:0]  s_axi_araddr,                   // read address
   input  wire        s_axi_arvalid,                  // read address valid
   output wire        s_axi_arready,                  // read address ready
   output reg  [31:0] s_axi_rdata,                    // read data
   output reg  [1:0]  s_axi_rresp,                    // read response
   output reg         s_axi_rvalid,                   // read data valid
   input  wire        s_axi_rready,                   // read data ready
   output wire [18:0] flash_addr,                     // flash address lines
   output wire [15:0] flash_dq_o,                     // flash data out
   output wire        flash_dq_oe,                    // flash data enable
   input  wire [15:0] flash_dq_i,                     // flash data in
   output wire        flash_ce_n,                     // chip select
   output wire        flash_oe_n,                     // output enable
   output wire        flash_we_n,                     // write strobe
   output wire        identification_address_line_hv, // high voltage on id line
   output reg         reset_pin_hv,                   // high voltage on reset pin
   input  wire        supply_ok                       // supply above lockout threshold
);
   localparam S_IDLE  = 4'b0001;
   localparam S_ISSUE = 4'b0010;
   localparam S_WAIT  = 4'b0100;
   localparam S_POST  = 4'b1000;
   localparam [1:0] RESP_OKAY   = 2'b00;
   localparam [1:0] RESP_SLVERR = 2'b10;

   reg  [3:0]  state;
   reg  [3:0]  op;
   reg         auto_rst;
   reg  [1:0]  sel;
   reg  [1:0]  step;
   reg         cyc_start;
   reg         done_flag;
   reg         refused;
   reg         id_mode;
   reg         timeout_seen;
   reg  [21:0] prot_mask;
   reg  [18:0] cur_addr;
   reg  [15:0] cur_wdata;
   reg  [4:0]  sect;
   reg         hv_rst_req;
   reg         sup_s1;
   reg         sup_s2;
   reg         aw_got;
   reg         w_got;
   reg  [7:0]  aw_q;
   reg  [31:0] wd_q;
   reg  [3:0]  ws_q;
   reg         st_wr;
   reg         st_hv;
   reg         st_last;
   reg  [18:0] st_addr;
   reg  [15:0] st_data;
   reg  [31:0] rd_mux;
   reg         rd_ok;
   wire        cyc_done;
   wire [15:0] cyc_rdata;
   wire        lockout;
   wire        busy;
   wire        wr_fire;
   wire        start_req;
   wire [31:0] lane;
   wire        op_writes;
   wire [11:0] u_addr;
   wire [15:0] u_data;

   assign lockout   = ~sup_s2;
   assign busy      = (state != S_IDLE);
   assign wr_fire   = aw_got & w_got & ~s_axi_bvalid;
   assign start_req = wr_fire & (aw_q == `REG_CTRL) & ws_q[0];
   assign lane      = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
   assign op_writes = (wd_q[`CTRL_OP] != `OP_READ) && (wd_q[`CTRL_OP] != `OP_HVID);
   assign u_addr    = step[0] ? `UNLOCK2_ADDR : `UNLOCK1_ADDR;
   assign u_data    = step[0] ? `UNLOCK2_DATA : `UNLOCK1_DATA;

   // supply indication is a pin: two flops before use
   always @(posedge aclk) begin
      if (!aresetn) begin
         sup_s1 <= 1'b0;
         sup_s2 <= 1'b0;
      end else begin
         sup_s1 <= supply_ok;
         sup_s2 <= sup_s1;
      end
   end

   // bus cycle for the current step of the current operation
   always @* begin
      st_wr   = 1'b0;
      st_hv   = 1'b0;
      st_last = 1'b1;
      st_addr = cur_addr;
      st_data = cur_wdata;
      case (op)
         `OP_READ: st_wr = 1'b0;
         `OP_WRITE: st_wr = 1'b1;
         `OP_RESET: begin
            st_wr   = 1'b1;
            st_addr = `RST_ADDR;
            st_data = `CMD_RESET;
         end
         `OP_ASEL: begin
            // two unlocks, then bank address with the identify command
            st_wr = 1'b1;
            if (step == 2'd2) begin
               st_addr = {cur_addr[18:12], `UNLOCK1_ADDR};
               st_data = `CMD_ASEL;
            end else begin
               st_last = 1'b0;
               st_addr = {7'h00, u_addr};
               st_data = u_data;
            end
         end
         `OP_PROG: begin
            // full unlock sequence so a lone write never programs
            st_wr = 1'b1;
            if (step == 2'd3) begin
               st_addr = cur_addr;
            end else if (step == 2'd2) begin
               st_last = 1'b0;
               st_addr = {7'h00, `UNLOCK1_ADDR};
               st_data = `CMD_PROG;
            end else begin
               st_last = 1'b0;
               st_addr = {7'h00, u_addr};
               st_data = u_data;
            end
         end
         `OP_HVID: begin
            // sector bits from the address, line six low, lines one and zero from selection
            st_hv   = 1'b1;
            st_addr = {cur_addr[18:12], 5'h00, 1'b0, 4'h0, sel};
         end
         default: st_wr = 1'b0;
      endcase
   end

   // operation sequencer
   always @(posedge aclk) begin
      if (!aresetn) begin
         state        <= S_IDLE;
         op           <= `OP_READ;
         auto_rst     <= 1'b0;
         sel          <= `HVSEL_MANUF;
         step         <= 2'd0;
         cyc_start    <= 1'b0;
         done_flag    <= 1'b0;
         refused      <= 1'b0;
         id_mode      <= 1'b0;
         timeout_seen <= 1'b0;
         prot_mask    <= `RST_PROT;
      end else begin
         cyc_start <= 1'b0;
         case (state)
            S_IDLE: begin
               if (start_req) begin
                  if (lockout && op_writes) begin
                     refused <= 1'b1;
                  end else begin
                     op        <= wd_q[`CTRL_OP];
                     auto_rst  <= wd_q[`CTRL_AUTO_RST];
                     sel       <= wd_q[`CTRL_SEL];
                     step      <= 2'd0;
                     done_flag <= 1'b0;
                     refused   <= 1'b0;
                     state     <= S_ISSUE;
                  end
               end
            end
            S_ISSUE: begin
               // a write step met with low supply is dropped, not issued
               if (lockout && st_wr) begin
                  refused   <= 1'b1;
                  done_flag <= 1'b1;
                  state     <= S_IDLE;
               end else begin
                  cyc_start <= 1'b1;
                  state     <= S_WAIT;
               end
            end
            S_WAIT: begin
               if (cyc_done) begin
                  if (st_last) begin
                     state <= S_POST;
                  end else begin
                     step  <= step + 2'd1;
                     state <= S_ISSUE;
                  end
               end
            end
            S_POST: begin
               done_flag <= 1'b1;
               state     <= S_IDLE;
               if (op == `OP_ASEL) begin
                  id_mode <= 1'b1;
               end
               if (op == `OP_RESET) begin
                  id_mode <= 1'b0;
               end
               if (op == `OP_HVID && sel == `HVSEL_PROT && sect < `NUM_SECTORS) begin
                  prot_mask[sect] <= cyc_rdata[0];
               end
               // timeout flag seen during a status read: issue the reset command
               if (op == `OP_READ && auto_rst && cyc_rdata[`TIMEOUT_FLAG_POS]) begin
                  timeout_seen <= 1'b1;
                  op           <= `OP_RESET;
                  step         <= 2'd0;
                  done_flag    <= 1'b0;
                  state        <= S_ISSUE;
               end
            end
            default: state <= S_IDLE;
         endcase
         if (start_req && busy) begin
            refused <= 1'b1;
         end
      end
   end

   // reset-pin high voltage only once every sector reads back protected
   always @(posedge aclk) begin
      if (!aresetn) begin
         reset_pin_hv <= 1'b0;
      end else begin
         reset_pin_hv <= hv_rst_req & (&prot_mask) & ~lockout;
      end
   end

   // register bus write side: address and data may arrive in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_got       <= 1'b0;
         w_got        <= 1'b0;
         aw_q         <= 8'h00;
         wd_q         <= 32'h00000000;
         ws_q         <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         cur_addr     <= `RST_ADDR;
         cur_wdata    <= `RST_WDATA;
         sect         <= `RST_SECT;
         hv_rst_req   <= 1'b0;
      end else begin
         if (s_axi_awvalid && !aw_got) begin
            aw_got <= 1'b1;
            aw_q   <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_got) begin
            w_got <= 1'b1;
            wd_q  <= s_axi_wdata;
            ws_q  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= RESP_OKAY;
            case (aw_q)
               `REG_CTRL: begin
                  if (ws_q[0]) begin
                     hv_rst_req <= wd_q[`CTRL_HV_RST];
                  end
               end
               `REG_ADDR: cur_addr <= (cur_addr & ~lane[18:0]) | (wd_q[18:0] & lane[18:0]);
               `REG_WDATA: cur_wdata <= (cur_wdata & ~lane[15:0]) | (wd_q[15:0] & lane[15:0]);
               `REG_SECT: begin
                  if (ws_q[0]) begin
                     sect <= wd_q[4:0];
                  end
               end
               `REG_STATUS, `REG_RDATA, `REG_PROT: s_axi_bresp <= RESP_OKAY;
               default: s_axi_bresp <= RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
         end
      end
   end

   assign s_axi_awready = ~aw_got;
   assign s_axi_wready  = ~w_got;
   assign s_axi_arready = ~s_axi_rvalid;

   // read decode
   always @* begin
      rd_ok  = 1'b1;
      rd_mux = 32'h00000000;
      case (s_axi_araddr)
         `REG_CTRL: rd_mux = {24'h000000, sel, 1'b0, auto_rst, op};
         `REG_ADDR: rd_mux = {13'h0000, cur_addr};
         `REG_WDATA: rd_mux = {16'h0000, cur_wdata};
         `REG_STATUS: rd_mux = {25'h0000000, reset_pin_hv, timeout_seen, id_mode, lockout, refused, done_flag, busy};
         `REG_RDATA: rd_mux = {16'h0000, cyc_rdata};
         `REG_PROT: rd_mux = {10'h000, prot_mask};
         `REG_SECT: rd_mux = {27'h0000000, sect};
         default: rd_ok = 1'b0;
      endcase
   end

   // register bus read side, answer one cycle after the address is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   flash_bus_cycle u_cycle (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .start       (cyc_start),
      .is_write    (st_wr),
      .hv          (st_hv),
      .addr        (st_addr),
      .wdata       (st_data),
      .done        (cyc_done),
      .rdata       (cyc_rdata),
      .fl_addr     (flash_addr),
      .fl_dq_o     (flash_dq_o),
      .fl_dq_oe    (flash_dq_oe),
      .fl_dq_i     (flash_dq_i),
      .fl_ce_n     (flash_ce_n),
      .fl_oe_n     (flash_oe_n),
      .fl_we_n     (flash_we_n),
      .fl_hv_id_en (identification_address_line_hv)
   );
endmodule // flash_id_host

// ### tb/host_chk.sv
`timescale 1ns/1ps
module host_chk (
   input wire        aclk, // clock
   input wire        aresetn, // reset, active low
   input wire [18:0] flash_addr, // address lines
   input wire [15:0] flash_dq_o, // write data
   input wire        flash_dq_oe, // data enable
   input wire        flash_ce_n, // select
   input wire        flash_oe_n, // output enable
   input wire        flash_we_n, // write strobe
   input wire        identification_address_line_hv, // id high voltage
   input wire        supply_ok // supply good
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // the strobe may only fall inside a qualified write
   strb_qual_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n) else $error("unqualified write");
   // five cycles low, far above any glitch the device filters
   we_width_a: assert property ($fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n) else $error("bad pulse");
   // address and data settled before the strobe falls
   addr_setup_a: assert property ($fell(flash_we_n) |-> flash_dq_oe && $stable(flash_addr)
      && $stable(flash_dq_o)) else $error("setup moved");
   data_hold_a: assert property ($rose(flash_we_n) |-> flash_dq_oe && $stable(flash_dq_o)
      && $stable(flash_addr)) else $error("hold moved");
   no_fight_a: assert property (!flash_oe_n |-> !flash_dq_oe) else $error("bus contention");
   hv_read_a: assert property (identification_address_line_hv && !flash_ce_n |-> flash_we_n && !flash_oe_n
      && !flash_addr[6]) else $error("bad id read");
   // a write issued just before the drop may finish: sync delay, start and pulse fit in twelve cycles
   lock_idle_a: assert property (!supply_ok [*8] ##1 !supply_ok [*4] |-> flash_we_n)
      else $error("write in lockout");
   rst_idle_a: assert property ($rose(aresetn) |-> flash_ce_n && flash_we_n && flash_oe_n && !flash_dq_oe)
      else $error("strobes after reset");
   cover property ($rose(identification_address_line_hv));
   cover property ($fell(flash_we_n));
   cover property (!supply_ok [*8]);
endmodule // host_chk

bind flash_id_host host_chk chk (.*);

// ### tb/flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model #(
   parameter [7:0]  MANUF = 8'h3C, // arbitrary value
   parameter [15:0] DEVICE = 16'h7E5D, // arbitrary value
   parameter [31:0] PROT_MSK = 32'h00000000 // shipped all unprotected
) (
   input  wire [18:0] addr, // address lines
   input  wire [15:0] dq_o, // data from host
   input  wire        ce_n, // select
   input  wire        oe_n, // output enable
   input  wire        we_n, // write strobe
   input  wire        id_hv, // high voltage on id line
   input  wire        rst_hv, // high voltage on reset pin
   input  wire        pwr, // supply above lockout
   output wire [15:0] dq_i // data to host
);
   wire        wr = ~ce_n & ~we_n & oe_n;
   reg  [18:0] la;
   reg  [1:0]  st = 2'h0;
   reg         idm = 1'b0;
   reg  [31:0] prot = PROT_MSK;
   reg  [15:0] mem = 16'hFFFF;
   reg  [15:0] v;
   reg         pu_skip = 1'b0;
   // strobes already low as the supply comes up: that pulse carries no command
   always @(posedge pwr) pu_skip = wr;
   // address at the later fall of the pair
   always @(posedge wr) la = addr;
   // data at the earlier rise; any bad cycle drops back to the first unlock cycle, id mode kept
   always @(negedge wr) begin
      if (!pwr || pu_skip) st = 2'h0;
      else if (dq_o == 16'h00F0) begin
         idm = 1'b0;
         st = 2'h0;
      end else case (st)
         2'h0: st = (la[11:0] == 12'h555 && dq_o == 16'h00AA) ? 2'h1 : 2'h0;
         2'h1: st = (la[11:0] == 12'h2AA && dq_o == 16'h0055) ? 2'h2 : 2'h0;
         2'h2: begin
            idm = idm | (dq_o == 16'h0090);
            st = (dq_o == 16'h00A0) ? 2'h3 : 2'h0;
         end
         default: begin
            if (!prot[la[18:14]] || rst_hv) mem = dq_o;
            st = 2'h0;
         end
      endcase
      pu_skip = 1'b0;
   end
   // identification codes replace array data in either id mode
   always @* begin
      case (addr[1:0])
         2'h0: v = {8'h00, MANUF};
         2'h1: v = DEVICE;
         default: v = {15'h0, prot[addr[18:14]]};
      endcase
      // nothing is ever erase-suspended here, so array reads always answer
      if (!(id_hv || idm)) v = mem;
   end
   // a released bus shows the inverse, so a stale sample cannot match
   assign dq_i = (~ce_n & ~oe_n) ? v : ~v;
endmodule // flash_dev_model

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   reg         aclk = 1'b0;
   reg         aresetn = 1'b0;
   reg  [7:0]  s_axi_awaddr = 8'h00;
   reg         s_axi_awvalid = 1'b0;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg         s_axi_wvalid = 1'b0;
   reg  [7:0]  s_axi_araddr = 8'h00;
   reg         s_axi_arvalid = 1'b0;
   reg         supply_ok = 1'b1;
   wire [3:0]  s_axi_wstrb = 4'hF;
   wire        s_axi_bready = 1'b1;
   wire        s_axi_rready = 1'b1;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [18:0] flash_addr;
   wire [15:0] flash_dq_o, flash_dq_i;
   wire        flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, identification_address_line_hv, reset_pin_hv;
   int         fails = 0;
   int         num_checks = 0;
   flash_id_host dut (.*);
   flash_dev_model #(.PROT_MSK(32'h00000008)) flash (.addr(flash_addr), .dq_o(flash_dq_o), .ce_n(flash_ce_n),
      .oe_n(flash_oe_n), .we_n(flash_we_n), .id_hv(identification_address_line_hv), .rst_hv(reset_pin_hv),
      .pwr(supply_ok), .dq_i(flash_dq_i));
   always #4 aclk = ~aclk;
   task end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("unexpected %s: expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask
   task hang;
      fails++;
      $display("unexpected handshake: expected answer seen none");
      end_of_test;
   endtask
   // each valid drops at the edge that takes it; bready stays high
   task axw(input [7:0] a, input [31:0] d, output [1:0] r);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      r = s_axi_bresp;
      if (n == 50) hang;
   endtask
   task axr(input [7:0] a, output [31:0] d, output [1:0] r);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (n == 50) hang;
   endtask
   task wr(input [7:0] a, input [31:0] d);
      reg [1:0] r;
      axw(a, d, r);
      chk("bresp", 32'h0, {30'h0, r});
   endtask
   task rdc(input [7:0] a, input [31:0] e, input [31:0] m, input string nm);
      reg [31:0] d;
      reg [1:0]  r;
      axr(a, d, r);
      chk(nm, e, d & m);
   endtask
   // start an operation and poll until done without busy
   task op(input [31:0] c);
      reg [31:0] s;
      reg [1:0]  r;
      int        n;
      wr(8'h00, c);
      for (n = 0; n < 60; n++) begin
         axr(8'h0C, s, r);
         if (s[1:0] === 2'h2) break;
      end
      if (n == 60) hang;
   endtask
   initial begin
      reg [31:0] d;
      reg [1:0]  r;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      rdc(8'h0C, 32'h0, 32'h7F, "status");
      rdc(8'h14, 32'h0, 32'h3FFFFF, "prot");
      axr(8'h1C, d, r);
      chk("unmapped", 32'h2, {30'h0, r});
      wr(8'h04, 32'hFFFFFFFF);
      rdc(8'h04, 32'h7FFFF, 32'hFFFFFFFF, "addr");
      $display("test registers done");
      wr(8'h04, 32'h0);
      op(32'h05);
      rdc(8'h10, 32'h3C, 32'hFF, "manuf");
      op(32'h45);
      rdc(8'h10, 32'h7E5D, 32'hFFFF, "device");
      wr(8'h04, 32'h0C000);
      wr(8'h18, 32'h3);
      op(32'h85);
      rdc(8'h10, 32'h1, 32'hFF, "verify");
      rdc(8'h14, 32'h8, 32'h3FFFFF, "mask");
      $display("test high voltage id done");
      wr(8'h04, 32'h0);
      op(32'h03);
      rdc(8'h0C, 32'h10, 32'h10, "id mode");
      op(32'h00);
      rdc(8'h10, 32'h3C, 32'hFF, "cmd manuf");
      wr(8'h04, 32'h1);
      op(32'h00);
      rdc(8'h10, 32'h7E5D, 32'hFFFF, "cmd device");
      wr(8'h04, 32'h12345);
      op(32'h02);
      op(32'h00);
      rdc(8'h10, 32'hFFFF, 32'hFFFF, "array");
      $display("test command id done");
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h1234);
      op(32'h04);
      op(32'h00);
      rdc(8'h10, 32'h1234, 32'hFFFF, "program");
      wr(8'h08, 32'h00A0);
      op(32'h01);
      wr(8'h04, 32'h0C000);
      wr(8'h08, 32'h4321);
      op(32'h04);
      op(32'h00);
      rdc(8'h10, 32'h1234, 32'hFFFF, "protected");
      op(32'h10);
      rdc(8'h0C, 32'h20, 32'h20, "timeout reset");
      op(32'h20);
      rdc(8'h0C, 32'h0, 32'h40, "hv held off");
      $display("test program done");
      supply_ok <= 1'b0;
      repeat (8) @(posedge aclk);
      wr(8'h00, 32'h01);
      rdc(8'h0C, 32'h0C, 32'h0C, "lockout");
      supply_ok <= 1'b1;
      repeat (4) @(posedge aclk);
      $display("test lockout done");
      end_of_test;
   end
endmodule // testbench
